//--- rtl/usl_pkg.sv
// constants and types shared by the unsigned lane arithmetic slice
// Function
// - exchange add-sub: upper half of a plus lower half of b, halved, to upper
// - exchange add-sub: lower half of a minus upper half of b, halved, to lower
// - exchange sub-add: upper half of a minus lower half of b, halved, to upper
// - exchange sub-add: lower half of a plus upper half of b, halved, to lower
// - exchange halving operations never change the condition flags
// - halving halfword subtract: per 16-bit lane a minus b, shifted right one
// - halving byte subtract: per byte a minus b, shifted right one
// - byte chooser picks each byte from a or b by its flag bit
// - all lane operations here leave the status flags unmodified
// - sum of absolute byte differences written to destination
// - accumulate variant adds third operand to that sum
// - plain halfword subtract per lane, no halving, wraps unsigned
// - plain byte subtract per lane, wraps unsigned
package usl_pkg;
   localparam int unsigned USL_DATA_W  = 32;
   localparam int unsigned USL_REG_W   = 4;
   localparam int unsigned USL_FLAG_W  = 4;
   localparam int unsigned USL_LAT     = 1;
   localparam logic [31:0] USL_RST_RES = 32'h0000_0000;

   typedef enum logic [3:0] {
      USL_OP_HADD_HALF,
      USL_OP_HADD_BYTE,
      USL_OP_HASX,
      USL_OP_HSAX,
      USL_OP_HSUB_HALF,
      USL_OP_HSUB_BYTE,
      USL_OP_CHOOSE,
      USL_OP_SAD,
      USL_OP_SADA,
      USL_OP_SUB_HALF,
      USL_OP_SUB_BYTE
   } usl_op_e;
endpackage : usl_pkg

//--- rtl/usl_lane_alu.sv
// combinational lane arithmetic of the slice
`timescale 1ns/1ps
`default_nettype none
module usl_lane_alu
(
   input  wire usl_pkg::usl_op_e       i_op,
   input  wire logic [31:0]            i_a,
   input  wire logic [31:0]            i_b,
   input  wire logic [31:0]            i_acc,
   input  wire logic [3:0]             i_lane_greater_equal,
   output logic [31:0]                 o_res
);
   import usl_pkg::*;

   // a 17-bit sum keeps the carry, so halving drops only the low bit
   function automatic logic [15:0] half_add16(input logic [15:0] x, input logic [15:0] y);
      logic [16:0] s;
      s = {1'b0, x} + {1'b0, y};
      return s[16:1];
   endfunction : half_add16

   // borrow bit lands in msb after halving
   function automatic logic [15:0] half_sub16(input logic [15:0] x, input logic [15:0] y);
      logic [16:0] s;
      s = {1'b0, x} - {1'b0, y};
      return s[16:1];
   endfunction : half_sub16

   function automatic logic [7:0] half_add8(input logic [7:0] x, input logic [7:0] y);
      logic [8:0] s;
      s = {1'b0, x} + {1'b0, y};
      return s[8:1];
   endfunction : half_add8

   function automatic logic [7:0] half_sub8(input logic [7:0] x, input logic [7:0] y);
      logic [8:0] s;
      s = {1'b0, x} - {1'b0, y};
      return s[8:1];
   endfunction : half_sub8

   function automatic logic [7:0] abs_diff8(input logic [7:0] x, input logic [7:0] y);
      logic [7:0] d;
      d = (x >= y) ? (x - y) : (y - x);
      return d;
   endfunction : abs_diff8

   always_comb
   begin
      logic [9:0] sad;
      sad   = 10'h000;
      o_res = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
      begin
         sad = sad + {2'b00, abs_diff8(i_a[8*i +: 8], i_b[8*i +: 8])};
      end
      unique case (i_op)
         USL_OP_HADD_HALF:
            o_res = {half_add16(i_a[31:16], i_b[31:16]), half_add16(i_a[15:0], i_b[15:0])};
         USL_OP_HADD_BYTE:
            for (int i = 0; i < 4; i++)
            begin
               o_res[8*i +: 8] = half_add8(i_a[8*i +: 8], i_b[8*i +: 8]);
            end
         USL_OP_HASX:
            o_res = {half_add16(i_a[31:16], i_b[15:0]), half_sub16(i_a[15:0], i_b[31:16])};
         USL_OP_HSAX:
            o_res = {half_sub16(i_a[31:16], i_b[15:0]), half_add16(i_a[15:0], i_b[31:16])};
         USL_OP_HSUB_HALF:
            o_res = {half_sub16(i_a[31:16], i_b[31:16]), half_sub16(i_a[15:0], i_b[15:0])};
         USL_OP_HSUB_BYTE:
            for (int i = 0; i < 4; i++)
            begin
               o_res[8*i +: 8] = half_sub8(i_a[8*i +: 8], i_b[8*i +: 8]);
            end
         USL_OP_CHOOSE:
            for (int i = 0; i < 4; i++)
            begin
               o_res[8*i +: 8] = i_lane_greater_equal[i] ? i_a[8*i +: 8] : i_b[8*i +: 8];
            end
         USL_OP_SAD:
            o_res = {22'h000000, sad};
         USL_OP_SADA:
            o_res = i_acc + {22'h000000, sad};
         USL_OP_SUB_HALF:
            o_res = {i_a[31:16] - i_b[31:16], i_a[15:0] - i_b[15:0]};
         USL_OP_SUB_BYTE:
            for (int i = 0; i < 4; i++)
            begin
               o_res[8*i +: 8] = i_a[8*i +: 8] - i_b[8*i +: 8];
            end
         default:
            o_res = 32'h0000_0000;
      endcase
   end
endmodule : usl_lane_alu
`default_nettype wire

//--- rtl/usl_top.sv
// registered top of the unsigned lane arithmetic slice
`timescale 1ns/1ps
`default_nettype none
module usl_top
(
   input  wire logic                   I_CLK_SYS,
   input  wire logic                   I_RST,
   input  wire logic                   I_VALID,
   input  wire usl_pkg::usl_op_e       I_OP,
   input  wire logic [31:0]            I_OPND_A,
   input  wire logic [31:0]            I_OPND_B,
   input  wire logic [31:0]            I_OPND_ACC,
   input  wire logic [3:0]             I_LANE_GREATER_EQUAL_FLAGS,
   input  wire logic                   I_COND_PASS,
   input  wire logic                   I_DEST_GIVEN,
   input  wire logic [3:0]             I_DEST_REG,
   input  wire logic [3:0]             I_SRC_A_REG,
   output logic                        O_WR_EN,
   output logic [3:0]                  O_WR_REG,
   output logic [31:0]                 O_WR_DATA,
   output logic                        O_FLAGS_WR
);
   import usl_pkg::*;

   // every check below runs on the core clock and sleeps through reset
   default clocking cb_sys @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);

   typedef struct packed {
      logic        wr_en;
      logic [3:0]  wr_reg;
      logic [31:0] wr_data;
   } usl_state_s;

   usl_state_s  st_q;
   usl_state_s  st_d;
   logic [31:0] alu_res;

   usl_lane_alu u_alu (
      .i_op                 (I_OP),
      .i_a                  (I_OPND_A),
      .i_b                  (I_OPND_B),
      .i_acc                (I_OPND_ACC),
      .i_lane_greater_equal (I_LANE_GREATER_EQUAL_FLAGS),
      .o_res                (alu_res)
   );

   always_comb
   begin
      st_d = st_q;
      st_d.wr_en = I_VALID & I_COND_PASS;
      if (I_VALID & I_COND_PASS)
      begin
         st_d.wr_reg  = I_DEST_GIVEN ? I_DEST_REG : I_SRC_A_REG;
         st_d.wr_data = alu_res;
      end
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RST)
      begin
         st_q <= '{wr_en: 1'b0, wr_reg: 4'h0, wr_data: USL_RST_RES};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign O_WR_EN   = st_q.wr_en;
   assign O_WR_REG  = st_q.wr_reg;
   assign O_WR_DATA = st_q.wr_data;
   // no operation here writes the flags
   assign O_FLAGS_WR = 1'b0;

   // reference byte distance total, kept apart from the lane unit
   function automatic logic [31:0] ref_sad(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] t;
      t = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
      begin
         if (a[8*i +: 8] > b[8*i +: 8])
         begin
            t = t + 32'(a[8*i +: 8] - b[8*i +: 8]);
         end
         else
         begin
            t = t + 32'(b[8*i +: 8] - a[8*i +: 8]);
         end
      end
      return t;
   endfunction : ref_sad

   chk_hasx_high: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_HASX
      |=> O_WR_DATA[31:16] == 16'(({1'b0, $past(I_OPND_A[31:16])}
                                   + {1'b0, $past(I_OPND_B[15:0])}) >> 1))
   else
      $error("exchange add-sub upper half wrong");

   chk_hasx_low: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_HASX
      |=> O_WR_DATA[15:0] == 16'(({1'b0, $past(I_OPND_A[15:0])}
                                  - {1'b0, $past(I_OPND_B[31:16])}) >> 1))
   else
      $error("exchange add-sub lower half wrong");

   chk_hsax_high: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_HSAX
      |=> O_WR_DATA[31:16] == 16'(({1'b0, $past(I_OPND_A[31:16])}
                                   - {1'b0, $past(I_OPND_B[15:0])}) >> 1))
   else
      $error("exchange sub-add upper half wrong");

   chk_hsax_low: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_HSAX
      |=> O_WR_DATA[15:0] == 16'(({1'b0, $past(I_OPND_A[15:0])}
                                  + {1'b0, $past(I_OPND_B[31:16])}) >> 1))
   else
      $error("exchange sub-add lower half wrong");

   chk_flags_kept: assert property (
      !O_FLAGS_WR)
   else
      $error("flags written");

   chk_hsub_half: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_HSUB_HALF
      |=> O_WR_DATA[31:16] == 16'(({1'b0, $past(I_OPND_A[31:16])}
                                   - {1'b0, $past(I_OPND_B[31:16])}) >> 1)
          && O_WR_DATA[15:0] == 16'(({1'b0, $past(I_OPND_A[15:0])}
                                     - {1'b0, $past(I_OPND_B[15:0])}) >> 1))
   else
      $error("halving halfword subtract wrong");

   chk_hsub_byte: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_HSUB_BYTE
      |=> O_WR_DATA[31:24] == 8'(({1'b0, $past(I_OPND_A[31:24])}
                                  - {1'b0, $past(I_OPND_B[31:24])}) >> 1)
          && O_WR_DATA[7:0] == 8'(({1'b0, $past(I_OPND_A[7:0])}
                                   - {1'b0, $past(I_OPND_B[7:0])}) >> 1))
   else
      $error("halving byte subtract wrong");

   chk_choose_byte: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_CHOOSE
      |=> O_WR_DATA[7:0] == ($past(I_LANE_GREATER_EQUAL_FLAGS[0])
                             ? $past(I_OPND_A[7:0]) : $past(I_OPND_B[7:0]))
          && O_WR_DATA[31:24] == ($past(I_LANE_GREATER_EQUAL_FLAGS[3])
                                  ? $past(I_OPND_A[31:24]) : $past(I_OPND_B[31:24])))
   else
      $error("chooser byte wrong");

   chk_sad_total: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_SAD
      |=> O_WR_DATA == ref_sad($past(I_OPND_A), $past(I_OPND_B)))
   else
      $error("absolute difference total wrong");

   chk_sada_total: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_SADA
      |=> O_WR_DATA == ref_sad($past(I_OPND_A), $past(I_OPND_B)) + $past(I_OPND_ACC))
   else
      $error("accumulated difference total wrong");

   chk_sub_half: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_SUB_HALF
      |=> O_WR_DATA[31:16] == 16'($past(I_OPND_A[31:16]) - $past(I_OPND_B[31:16]))
          && O_WR_DATA[15:0] == 16'($past(I_OPND_A[15:0]) - $past(I_OPND_B[15:0])))
   else
      $error("halfword subtract wrong");

   chk_sub_byte: assert property (
      I_VALID && I_COND_PASS && I_OP == USL_OP_SUB_BYTE
      |=> O_WR_DATA[23:16] == 8'($past(I_OPND_A[23:16]) - $past(I_OPND_B[23:16]))
          && O_WR_DATA[15:8] == 8'($past(I_OPND_A[15:8]) - $past(I_OPND_B[15:8])))
   else
      $error("byte subtract wrong");

   chk_dest_default: assert property (
      I_VALID && I_COND_PASS && !I_DEST_GIVEN
      |=> O_WR_REG == $past(I_SRC_A_REG))
   else
      $error("default destination wrong");

   chk_dest_given: assert property (
      I_VALID && I_COND_PASS && I_DEST_GIVEN
      |=> O_WR_REG == $past(I_DEST_REG))
   else
      $error("given destination wrong");

   chk_wr_pulse: assert property (
      I_VALID && I_COND_PASS
      |=> O_WR_EN)
   else
      $error("writeback missing");

   chk_cond_fail: assert property (
      I_VALID && !I_COND_PASS
      |=> !O_WR_EN && $stable(O_WR_DATA) && $stable(O_WR_REG))
   else
      $error("writeback on failed condition");

   // main scenarios seen at least once
   cov_sada: cover property (I_VALID && I_COND_PASS && I_OP == USL_OP_SADA);
   cov_fail: cover property (I_VALID && !I_COND_PASS);
   cov_b2b: cover property (I_VALID ##1 I_VALID);
   cov_dest_default: cover property (I_VALID && I_COND_PASS && !I_DEST_GIVEN);
endmodule : usl_top
`default_nettype wire

//--- sim/usl_core_model.sv
// register file of the core side that takes the slice's writebacks
`timescale 1ns/1ps
`default_nettype none
module usl_core_model
(
   input  wire logic        i_clk,
   input  wire logic        i_wr_en,
   input  wire logic [3:0]  i_wr_reg,
   input  wire logic [31:0] i_wr_data,
   input  wire logic [3:0]  i_rd_reg,
   output logic [31:0]      o_rd_data
);
   logic [31:0] rf [16];
   // read side lets the bench see what the core really holds
   assign o_rd_data = rf[i_rd_reg];
   always_ff @(posedge i_clk)
   begin
      if (i_wr_en)
         rf[i_wr_reg] <= i_wr_data;
   end
endmodule : usl_core_model
`default_nettype wire

//--- sim/usl_top_tb.sv
// self-checking bench of the lane arithmetic slice against an integer model
`timescale 1ns/1ps
`default_nettype none
module usl_top_tb;
   import usl_pkg::*;
   logic I_CLK_SYS = 0, I_RST = 1, I_VALID = 0, I_COND_PASS = 0, I_DEST_GIVEN = 0;
   logic [31:0] I_OPND_A = 0, I_OPND_B = 0, I_OPND_ACC = 0;
   logic [3:0]  I_LANE_GREATER_EQUAL_FLAGS = 0, I_DEST_REG = 0, I_SRC_A_REG = 0;
   usl_op_e     I_OP = USL_OP_HADD_HALF;
   logic        O_WR_EN, O_FLAGS_WR;
   logic [3:0]  O_WR_REG;
   logic [31:0] O_WR_DATA, e_data;
   logic [3:0]  e_reg;
   logic        e_en, p_en = 0;
   logic [3:0]  p_reg = 0;
   logic [31:0] p_data = 0, rd_data;
   int          n_errors = 0, n_compared = 0, seed = 62, n, op;
   always #25 I_CLK_SYS = ~I_CLK_SYS;
   usl_top DUT (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_VALID(I_VALID), .I_OP(I_OP),
      .I_OPND_A(I_OPND_A), .I_OPND_B(I_OPND_B), .I_OPND_ACC(I_OPND_ACC),
      .I_LANE_GREATER_EQUAL_FLAGS(I_LANE_GREATER_EQUAL_FLAGS),
      .I_COND_PASS(I_COND_PASS), .I_DEST_GIVEN(I_DEST_GIVEN),
      .I_DEST_REG(I_DEST_REG), .I_SRC_A_REG(I_SRC_A_REG), .O_WR_EN(O_WR_EN),
      .O_WR_REG(O_WR_REG), .O_WR_DATA(O_WR_DATA), .O_FLAGS_WR(O_FLAGS_WR));
   usl_core_model core (.i_clk(I_CLK_SYS), .i_wr_en(O_WR_EN), .i_wr_reg(O_WR_REG),
      .i_wr_data(O_WR_DATA), .i_rd_reg(p_reg), .o_rd_data(rd_data));
   // halving keeps the borrow as msb, so differences are masked to lane width plus one
   function automatic logic [31:0] model(input int op, input logic [31:0] a, b, c,
                                         input logic [3:0] g);
      int ah, al, bh, bl, x, y, s, i;
      logic [31:0] r;
      ah = a[31:16];
      al = a[15:0];
      bh = b[31:16];
      bl = b[15:0];
      s = 0;
      r = 0;
      for (i = 0; i < 4; i++)
      begin
         x = a[8*i+:8];
         y = b[8*i+:8];
         case (op)
            1: r[8*i+:8] = 8'((x + y) >> 1);
            5: r[8*i+:8] = 8'(((x - y) & 32'h0000_01FF) >> 1);
            6: r[8*i+:8] = g[i] ? 8'(x) : 8'(y);
            10: r[8*i+:8] = 8'(x - y);
            default: s += (x > y) ? x - y : y - x;
         endcase
      end
      case (op)
         0: r = {16'((ah + bh) >> 1), 16'((al + bl) >> 1)};
         2: r = {16'((ah + bl) >> 1), 16'(((al - bh) & 32'h0001_FFFF) >> 1)};
         3: r = {16'(((ah - bl) & 32'h0001_FFFF) >> 1), 16'((al + bh) >> 1)};
         4: r = {16'(((ah - bh) & 32'h0001_FFFF) >> 1), 16'(((al - bl) & 32'h0001_FFFF) >> 1)};
         7: r = 32'(s);
         8: r = 32'(s) + c;
         9: r = {16'(ah - bh), 16'(al - bl)};
         default: ;
      endcase
      return r;
   endfunction : model
   task automatic cmp1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask : cmp1
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask : cmp32
   task automatic end_of_test();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   initial
   begin
      #60000;
      n_errors++;
      end_of_test();
   end
   initial
   begin
      e_data = 0;
      e_reg = 0;
      repeat (5) @(posedge I_CLK_SYS);
      #2;
      for (n = 0; n < 420; n++)
      begin
         // with the compare delay, inputs always move 5 ns after the edge
         #3;
         // a second reset in mid-run drops the op taken with it
         I_RST = (n == 200);
         op = $unsigned($random(seed)) % 11;
         I_OP = usl_op_e'(op);
         I_VALID = ($random(seed) & 7) != 0;
         I_COND_PASS = ($random(seed) & 3) != 0;
         I_DEST_GIVEN = 1'($random(seed));
         I_OPND_A = ($random(seed) & 1) ? $random(seed) : {32{1'($random(seed))}};
         I_OPND_B = ($random(seed) & 1) ? $random(seed) : {32{1'($random(seed))}};
         I_OPND_ACC = $random(seed);
         I_LANE_GREATER_EQUAL_FLAGS = 4'($random(seed));
         I_DEST_REG = 4'($unsigned($random(seed)) % 13);
         I_SRC_A_REG = 4'($unsigned($random(seed)) % 13);
         e_en = !I_RST && I_VALID && I_COND_PASS;
         if (I_RST)
            {e_reg, e_data} = '0;
         else if (e_en)
            {e_reg, e_data} = {I_DEST_GIVEN ? I_DEST_REG : I_SRC_A_REG,
               model(op, I_OPND_A, I_OPND_B, I_OPND_ACC, I_LANE_GREATER_EQUAL_FLAGS)};
         @(posedge I_CLK_SYS);
         #2;
         cmp1(O_WR_EN, e_en);
         cmp1(O_FLAGS_WR, 1'b0);
         cmp32(32'(O_WR_REG), 32'(e_reg));
         cmp32(O_WR_DATA, e_data);
         // the write of the previous cycle has landed in the core by now
         if (p_en)
         begin
            cmp32(rd_data, p_data);
         end
         {p_en, p_reg, p_data} = {e_en, e_reg, e_data};
      end
      end_of_test();
   end
endmodule : usl_top_tb
`default_nettype wire
